// ### rtl/uic_pkg.sv
// Package for the universal input counter unit.
// Assumes a 10 MHz hclk and an AHB-Lite slave with 32-bit data.
package uic_pkg;
    localparam int CLK_HZ = 10_000_000;
    // Gate times in milliseconds and derived cycle counts
    localparam int GATE_100MS = 100;
    localparam int GATE_1000MS = 1000;
    localparam int GATE_10000MS = 10000;
    localparam int GATE_SHORT_CYC = CLK_HZ / 1000 * GATE_100MS;
    localparam int GATE_MID_CYC = CLK_HZ / 1000 * GATE_1000MS;
    localparam int GATE_LONG_CYC = CLK_HZ / 1000 * GATE_10000MS;
    // Period timebase in microseconds
    localparam int PERIOD_TB_US = 1;
    localparam int PERIOD_TB_CYC = CLK_HZ / 1_000_000 * PERIOD_TB_US;
    // Register byte offsets
    localparam logic [7:0] OFS_CFG0 = 8'h00;
    localparam logic [7:0] OFS_CFG1 = 8'h04;
    localparam logic [7:0] OFS_RUN = 8'h08;
    localparam logic [7:0] OFS_VAL1 = 8'h0C;
    localparam logic [7:0] OFS_VAL2 = 8'h10;
    localparam logic [7:0] OFS_VAL3 = 8'h14;
    localparam logic [7:0] OFS_CTL = 8'h18;
    localparam logic [7:0] OFS_CNT1 = 8'h1C;
    localparam logic [7:0] OFS_CNT2 = 8'h20;
    localparam logic [7:0] OFS_CNT3 = 8'h24;
    localparam logic [7:0] OFS_STAT = 8'h28;
    localparam logic [7:0] OFS_ALARM = 8'h2C;
    localparam logic [7:0] OFS_INFO12 = 8'h30;
    localparam logic [7:0] OFS_INFO3 = 8'h34;
    // Control byte fields
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_LOAD_BIT = 1;
    // Per-input config field: bit0 edge falling, bit1 down, bit2 alarm enable, bit3 alarm input
    localparam int CF_FALL = 0;
    localparam int CF_DOWN = 1;
    localparam int CF_ALEN = 2;
    localparam int CF_ALIN = 3;
    localparam logic [31:0] CFG0_RST = 32'h0000_0000;
    localparam logic [15:0] ALARM_INFO_ONE = 16'h0110;
    localparam logic [15:0] ALARM_INFO_THREE = 16'h0110;
    typedef enum logic [1:0] {
        UIC_M3_OFF,
        UIC_M3_COUNT,
        UIC_M3_FREQ,
        UIC_M3_PERIOD
    } uic_mode3_e;
    typedef enum logic [1:0] {
        UIC_GATE_SHORT,
        UIC_GATE_MID,
        UIC_GATE_LONG
    } uic_gate_e;
endpackage

// ### rtl/uic_counter.sv
// One 16-bit event counter channel with load, direction and alarm.
// Assumes edge pulse and control inputs synchronous to hclk.
`timescale 1ns/100ps
module uic_counter (
    input  wire logic        hclk,      // Clock
    input  wire logic        hresetn,   // Async reset, low
    input  wire logic        edge_p,    // Count edge pulse
    input  wire logic        down,      // Count down
    input  wire logic        en,        // Control enable bit
    input  wire logic        ld,        // Control load bit
    input  wire logic [15:0] preset,    // Start or comparison value
    output logic      [15:0] count_q,   // Actual count
    output logic             hit_q      // Terminal pulse
);
    logic        en_q;
    logic        ld_q;
    logic        pend_q;
    logic [15:0] ref_q;
    wire         init = en & ~en_q & ld;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q <= 1'b0;
            ld_q <= 1'b0;
        end else begin
            en_q <= en;
            ld_q <= ld;
        end
    end

    // Load request takes effect at the next count edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= 1'b0;
        end else if (ld & ~ld_q) begin
            pend_q <= 1'b1;
        end else if (edge_p | init) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_q   <= 16'h0000; // R15
            count_q <= 16'h0000; // R15
            hit_q   <= 1'b0;
        end else begin
            hit_q <= 1'b0;
            if (init) begin
                ref_q   <= preset; // R19
                count_q <= down ? preset : 16'h0000; // R16
            end else if (en && edge_p) begin
                if (pend_q) begin
                    ref_q <= preset; // R17
                end
                if (!down) begin
                    if (count_q + 16'h0001 >= (pend_q ? preset : ref_q)) begin
                        count_q <= 16'h0000; // R19
                        hit_q   <= 1'b1; // R7
                    end else begin
                        count_q <= count_q + 16'h0001; // R14
                    end
                end else if (count_q == 16'h0000) begin
                    count_q <= pend_q ? preset : ref_q; // R19
                    hit_q   <= 1'b1; // R7
                end else begin
                    count_q <= count_q - 16'h0001; // R16
                end
            end
        end
    end

    AST_HIT_NEEDS_EDGE: assert property (@(posedge hclk) disable iff (!hresetn)
        hit_q |-> $past(edge_p) && $past(en)) else $error("Hit without enabled edge"); // R7
    AST_INIT_LOADS: assert property (@(posedge hclk) disable iff (!hresetn)
        init |=> count_q == (down ? $past(preset) : 16'h0000)) else $error("Init load wrong"); // R19
endmodule // uic_counter

// ### rtl/uic_top.sv
// Universal input counter unit: four field inputs, three counters,
// frequency/period meter on input 3, alarm info words, AHB-Lite slave.
// Assumes inputs synchronous to hclk and a single-slave AHB-Lite bus.
`timescale 1ns/100ps
// Function
// R1 - Parameters latched on stop to run
// R2 - Alarm input raises alarm on chosen edge
// R3 - Inputs 1-3 count; input 3 measures
// R4 - Counts 16 bit, measurements 24 bit
// R5 - Count direction up or down, up default
// R6 - Count edge rising or falling, rising default
// R7 - Terminal event raises alarm when enabled
// R8 - Input 3 mode select, off default
// R9 - Gate time 0.1, 1, 10 s
// R10 - Deactivated inputs readable as plain levels
// R11 - Info word one holds 0110h
// R12 - Info word two byte 8 input number
// R13 - Info word three holds 0110h
// R14 - Up count equals counted edges
// R15 - Up counter starts at zero
// R16 - Down counter starts from start value
// R17 - Control byte enable and load bits
// R18 - Status byte levels and counting flags
// R19 - Reinitialise at terminal or enable with load
// R20 - Frequency per gate, period per timebase
module uic_top #(
    parameter int GATE_SHORT = uic_pkg::GATE_SHORT_CYC,  // Short gate cycles
    parameter int GATE_MID   = uic_pkg::GATE_MID_CYC,    // Mid gate cycles
    parameter int GATE_LONG  = uic_pkg::GATE_LONG_CYC    // Long gate cycles
) (
    input  wire logic        hclk,       // Clock 10 MHz
    input  wire logic        hresetn,    // Async reset, low
    input  wire logic        hsel,       // Slave select
    input  wire logic [7:0]  haddr,      // Byte address
    input  wire logic [1:0]  htrans,     // Transfer type
    input  wire logic        hwrite,     // Write
    input  wire logic [2:0]  hsize,      // Size
    input  wire logic        hready,     // Bus ready
    input  wire logic [31:0] hwdata,     // Write data
    output logic      [31:0] hrdata,     // Read data
    output logic             hreadyout,  // Always ready
    output logic             hresp,      // Always OKAY
    input  wire logic [3:0]  uin,        // Field inputs
    output logic             alarm_q,    // Process alarm pulse
    output logic      [1:0]  alarm_src_q // Input number minus one
);
    initial begin
        if (GATE_SHORT < 1 || GATE_MID <= GATE_SHORT || GATE_LONG <= GATE_MID || GATE_LONG > 32'h7FFF_FFFF)
            $error("Bad gate counts");
    end

    logic [31:0] cfg0_q;   // Staged config: 4 bits per input, mode3 [17:16], gate [19:18]
    logic [31:0] act_q;    // Active config
    logic        run_q;
    logic [15:0] val_q [3];
    logic [7:0]  ctl_q;    // 2 bits per counter
    logic [3:0]  uin_q;
    logic [23:0] meas_q;
    logic        wr_q;
    logic [7:0]  wa_q;
    logic [3:0]  rise, fall, sel;
    logic [15:0] cnt [3];
    logic [2:0]  hit;

    wire uic_pkg::uic_mode3_e m3 = uic_pkg::uic_mode3_e'(act_q[17:16]);
    wire uic_pkg::uic_gate_e  gt = uic_pkg::uic_gate_e'(act_q[19:18]);
    wire addr_ph = hsel & hready & htrans[1];

    // One bit of an input's config nibble
    function automatic logic fld(input logic [31:0] c, input int i, input int b);
        fld = c[i*4 + b];
    endfunction

    assign rise = uin & ~uin_q;
    assign fall = ~uin & uin_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uin_q <= 4'h0;
        end else begin
            uin_q <= uin;
        end
    end

    // Bus slave: zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q      <= 1'b0;
            wa_q      <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_q <= addr_ph & hwrite;
            wa_q <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ph && !hwrite) begin
            unique case (haddr)
                uic_pkg::OFS_CFG0:   hrdata <= cfg0_q;
                uic_pkg::OFS_CFG1:   hrdata <= act_q;
                uic_pkg::OFS_RUN:    hrdata <= {31'h0000_0000, run_q};
                uic_pkg::OFS_VAL1:   hrdata <= {16'h0000, val_q[0]};
                uic_pkg::OFS_VAL2:   hrdata <= {16'h0000, val_q[1]};
                uic_pkg::OFS_VAL3:   hrdata <= {16'h0000, val_q[2]};
                uic_pkg::OFS_CTL:    hrdata <= {24'h00_0000, ctl_q};
                uic_pkg::OFS_CNT1:   hrdata <= {16'h0000, cnt[0]}; // R4
                uic_pkg::OFS_CNT2:   hrdata <= {16'h0000, cnt[1]};
                uic_pkg::OFS_CNT3:   hrdata <= (m3 == uic_pkg::UIC_M3_COUNT) ?
                                               {16'h0000, cnt[2]} : {8'h00, meas_q}; // R4
                uic_pkg::OFS_STAT:   hrdata <= {24'h00_0000, 1'b0, sel[2:0], uin_q}; // R18 R10
                uic_pkg::OFS_ALARM:  hrdata <= {30'h0000_0000, alarm_src_q};
                uic_pkg::OFS_INFO12: hrdata <= {8'(alarm_src_q) + 8'h01, 8'h00,
                                                uic_pkg::ALARM_INFO_ONE}; // R11 R12
                uic_pkg::OFS_INFO3:  hrdata <= {16'h0000, uic_pkg::ALARM_INFO_THREE}; // R13
                default:             hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg0_q <= uic_pkg::CFG0_RST;
            run_q  <= 1'b0;
            val_q  <= '{default: 16'h0000};
            ctl_q  <= 8'h00;
        end else if (wr_q) begin
            unique case (wa_q)
                uic_pkg::OFS_CFG0: cfg0_q   <= {12'h000, hwdata[19:18] == 2'b11 ? 2'b01 : hwdata[19:18],
                                                hwdata[17:0]}; // R8 R9
                uic_pkg::OFS_RUN:  run_q    <= hwdata[0];
                uic_pkg::OFS_VAL1: val_q[0] <= hwdata[15:0];
                uic_pkg::OFS_VAL2: val_q[1] <= hwdata[15:0];
                uic_pkg::OFS_VAL3: val_q[2] <= hwdata[15:0];
                uic_pkg::OFS_CTL:  ctl_q    <= hwdata[7:0]; // R17
                default: ;
            endcase
        end
    end

    // Active parameters taken at each stop to run change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_q <= uic_pkg::CFG0_RST;
        end else if (wr_q && wa_q == uic_pkg::OFS_RUN && hwdata[0] && !run_q) begin
            act_q <= cfg0_q; // R1
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sel
            assign sel[g] = fld(act_q, g, uic_pkg::CF_FALL) ? fall[g] : rise[g]; // R6 R2
        end
        for (g = 0; g < 3; g++) begin : g_cnt
            wire active = (g < 2) ? !fld(act_q, g, uic_pkg::CF_ALIN) : (m3 == uic_pkg::UIC_M3_COUNT); // R3 R8
            uic_counter u_cnt (
                .hclk    (hclk),
                .hresetn (hresetn),
                .edge_p  (sel[g] & active),
                .down    (fld(act_q, g, uic_pkg::CF_DOWN)), // R5
                .en      (ctl_q[2*g + uic_pkg::CTL_EN_BIT] & active & run_q),
                .ld      (ctl_q[2*g + uic_pkg::CTL_LOAD_BIT]),
                .preset  (val_q[g]),
                .count_q (cnt[g]),
                .hit_q   (hit[g])
            );
        end
    endgenerate

    // Frequency and period measurement on input 3
    logic [31:0] tmr_q;
    logic [23:0] acc_q;
    logic [31:0] gate_len;
    always_comb begin
        unique case (gt)
            uic_pkg::UIC_GATE_SHORT: gate_len = 32'(GATE_SHORT); // R9
            uic_pkg::UIC_GATE_LONG:  gate_len = 32'(GATE_LONG);
            default:                 gate_len = 32'(GATE_MID);
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmr_q  <= 32'h0000_0000;
            acc_q  <= 24'h00_0000;
            meas_q <= 24'h00_0000;
        end else if (!run_q) begin
            tmr_q <= 32'h0000_0000;
            acc_q <= 24'h00_0000;
        end else if (m3 == uic_pkg::UIC_M3_FREQ) begin
            if (tmr_q >= gate_len - 32'h0000_0001) begin
                tmr_q  <= 32'h0000_0000;
                meas_q <= acc_q + 24'(sel[2]); // R20
                acc_q  <= 24'h00_0000;
            end else begin
                tmr_q <= tmr_q + 32'h0000_0001;
                acc_q <= acc_q + 24'(sel[2]);
            end
        end else if (m3 == uic_pkg::UIC_M3_PERIOD) begin
            if (sel[2]) begin
                meas_q <= acc_q; // R20
                acc_q  <= 24'h00_0000;
                tmr_q  <= 32'h0000_0000;
            end else if (tmr_q >= 32'(uic_pkg::PERIOD_TB_CYC - 1)) begin
                tmr_q <= 32'h0000_0000;
                if (acc_q != 24'hFF_FFFF) acc_q <= acc_q + 24'h00_0001;
            end else begin
                tmr_q <= tmr_q + 32'h0000_0001;
            end
        end
    end

    // Process alarm: lowest numbered source wins
    logic [3:0] req;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            req[i] = fld(act_q, i, uic_pkg::CF_ALIN) ? sel[i] : 1'b0; // R2
        end
        for (int i = 0; i < 3; i++) begin
            req[i] = req[i] | (hit[i] & fld(act_q, i, uic_pkg::CF_ALEN)); // R7
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_q     <= 1'b0;
            alarm_src_q <= 2'b00;
        end else begin
            alarm_q <= |req & run_q;
            if (|req && run_q) begin
                alarm_src_q <= req[0] ? 2'd0 : req[1] ? 2'd1 : req[2] ? 2'd2 : 2'd3; // R12
            end
        end
    end

    AST_ACT_ON_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(run_q) |-> act_q == $past(cfg0_q)) else $error("Config not taken at run"); // R1
    AST_ALARM_CAUSE: assert property (@(posedge hclk) disable iff (!hresetn)
        alarm_q |-> $past(|req) && $past(run_q)) else $error("Alarm without cause"); // R2
    AST_STAT_LEVELS: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ph && !hwrite && haddr == uic_pkg::OFS_STAT |=> hrdata[3:0] == $past(uin_q))
        else $error("Status levels wrong"); // R18
    AST_INFO3: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ph && !hwrite && haddr == uic_pkg::OFS_INFO3 |=> hrdata == 32'h0000_0110)
        else $error("Info three wrong"); // R13
    AST_INFO1: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ph && !hwrite && haddr == uic_pkg::OFS_INFO12 |=> hrdata[15:0] == 16'h0110)
        else $error("Info one wrong"); // R11
    AST_M3_OFF_NOCNT: assert property (@(posedge hclk) disable iff (!hresetn)
        m3 == uic_pkg::UIC_M3_OFF && $stable(act_q) |=> $stable(cnt[2])) else $error("Input 3 counted off"); // R8
    AST_UP_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
        sel[0] && ctl_q[0] && run_q && !act_q[1] && !act_q[3] && $stable(ctl_q) && cnt[0] + 16'h0001 < val_q[0]
        |=> cnt[0] == $past(cnt[0]) + 16'h0001) else $error("Up count step wrong"); // R14
    AST_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp) else $error("Slave not ready/okay"); // R17
endmodule // uic_top

// ### sim/uic_field_src.sv
// Field input source standing in for the process side of the unit.
// Assumes the bench calls its tasks just after a rising edge of hclk.
`timescale 1ns/100ps
module uic_field_src (
    output logic [3:0] uin,  // Field input levels
    input  wire logic  hclk  // Clock
);
    initial uin = 4'h0;

    // Sets all four levels at the next edge
    task automatic drive(input logic [3:0] v);
        @(posedge hclk);
        uin <= v;
    endtask

    // Square pulses on one input, half a period per level
    task automatic pulse(input int idx, input int n, input int half);
        for (int p = 0; p < n; p++) begin
            @(posedge hclk);
            uin[idx] <= 1'b1;
            repeat (half) @(posedge hclk);
            uin[idx] <= 1'b0;
            repeat (half - 1) @(posedge hclk);
        end
    endtask
endmodule // uic_field_src

// ### sim/uic_top_tb.sv
// Self-checking bench for the universal input counter unit.
// Assumes the unit is the only AHB-Lite slave; gates shortened.
`timescale 1ns/100ps
module uic_top_tb;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [3:0]  uin;
    logic        alarm_q;
    logic [1:0]  alarm_src_q;
    logic [31:0] rd;
    int          fail_count = 0;
    int          tests_run = 0;
    int          alarm_n = 0;
    int          a;

    uic_top #(.GATE_SHORT(200), .GATE_MID(400), .GATE_LONG(800)) uic_top_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .uin(uin),
        .alarm_q(alarm_q), .alarm_src_q(alarm_src_q));
    uic_field_src uic_field_src_i (.uin(uin), .hclk(hclk));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // Counts one-cycle alarm pulses
    always @(posedge hclk) begin
        if (alarm_q === 1'b1) begin
            alarm_n <= alarm_n + 1;
        end
    end

    task automatic stop_test();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Single word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] adr, input logic [31:0] wd);
        int k;
        k = 0;
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= adr;
        hwrite <= w;
        hsize  <= 3'b010;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hsize  <= 3'b000;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        rd = hrdata;
        if (k >= 100) begin
            fail_count++;
            stop_test();
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Stages config, then a stop to run transition
    task automatic run(input logic [31:0] cfg);
        bus(1'b1, uic_pkg::OFS_CFG0, cfg);
        bus(1'b1, uic_pkg::OFS_RUN, 32'h0000_0000);
        bus(1'b1, uic_pkg::OFS_RUN, 32'h0000_0001);
        bus(0, uic_pkg::OFS_CFG1, 0);
        check(rd, cfg);
    endtask

    task automatic t_reset();
        bus(0, uic_pkg::OFS_CFG0, 0);
        check(rd, uic_pkg::CFG0_RST);
        bus(0, uic_pkg::OFS_CNT1, 0);
        check(rd, 32'h0000_0000);
        bus(0, 8'h3C, 0);
        check(rd, 32'h0000_0000);
    endtask

    task automatic t_up();
        run(32'h0000_0004);
        bus(1'b1, uic_pkg::OFS_VAL1, 32'h0000_0003);
        bus(1'b1, uic_pkg::OFS_CTL, 32'h0000_0002);
        bus(1'b1, uic_pkg::OFS_CTL, 32'h0000_0003);
        uic_field_src_i.pulse(0, 2, 5);
        idle(4);
        bus(0, uic_pkg::OFS_CNT1, 0);
        check(rd, 32'h0000_0002);
        a = alarm_n;
        uic_field_src_i.pulse(0, 1, 5);
        idle(4);
        check(32'(alarm_n - a), 1);
        check({30'h0, alarm_src_q}, 0);
        bus(0, uic_pkg::OFS_CNT1, 0);
        check(rd, 32'h0000_0000);
        bus(0, uic_pkg::OFS_INFO12, 0);
        check(rd & 32'hFF00_FFFF, 32'h0100_0110);
        bus(1'b1, uic_pkg::OFS_CTL, 32'h0000_0000);
        uic_field_src_i.pulse(0, 1, 5);
        idle(4);
        bus(0, uic_pkg::OFS_CNT1, 0);
        check(rd, 32'h0000_0000);
    endtask

    task automatic t_down();
        run(32'h0000_0070);
        bus(1'b1, uic_pkg::OFS_VAL2, 32'h0000_0002);
        bus(1'b1, uic_pkg::OFS_CTL, 32'h0000_0008);
        bus(1'b1, uic_pkg::OFS_CTL, 32'h0000_000C);
        uic_field_src_i.drive(4'b0010);
        idle(4);
        bus(0, uic_pkg::OFS_CNT2, 0);
        check(rd, 32'h0000_0002);
        uic_field_src_i.drive(4'b0000);
        idle(4);
        bus(0, uic_pkg::OFS_CNT2, 0);
        check(rd, 32'h0000_0001);
        a = alarm_n;
        uic_field_src_i.pulse(1, 2, 5);
        idle(4);
        check(32'(alarm_n - a), 1);
        check({30'h0, alarm_src_q}, 1);
    endtask

    // Alarm input 4, rising default then falling
    task automatic t_alarm_in();
        for (int f = 0; f < 2; f++) begin
            run(f ? 32'h0000_9000 : 32'h0000_8000);
            a = alarm_n;
            uic_field_src_i.drive(4'b1000);
            idle(4);
            check(32'(alarm_n - a), f ? 0 : 1);
            bus(0, uic_pkg::OFS_STAT, 0);
            check(rd & 32'h0000_000F, 32'h0000_0008);
            uic_field_src_i.drive(4'b0000);
            idle(4);
            check(32'(alarm_n - a), 1);
        end
        check({30'h0, alarm_src_q}, 3);
        bus(0, uic_pkg::OFS_INFO12, 0);
        check(rd & 32'hFF00_FFFF, 32'h0400_0110);
        bus(0, uic_pkg::OFS_INFO3, 0);
        check(rd, 32'h0000_0110);
    endtask

    // Three gate times, then period mode, on input 3
    task automatic t_meas();
        int g;
        int half;
        int cyc;
        int exp;
        for (int i = 0; i < 4; i++) begin
            g = (i < 3) ? i : 1;
            half = (i < 3) ? 5 : 50;
            cyc = (i == 0) ? 200 : (i == 1) ? 400 : 800;
            run((32'(g) << 18) | (((i < 3) ? 32'h2 : 32'h3) << 16));
            bus(1'b1, uic_pkg::OFS_CTL, 32'h0000_0030);
            fork
                uic_field_src_i.pulse(2, (2 * cyc + 400) / (2 * half), half);
            join_none
            idle(2 * cyc + 100);
            bus(0, uic_pkg::OFS_CNT3, 0);
            exp = (i < 3) ? cyc / (2 * half) : 2 * half / uic_pkg::PERIOD_TB_CYC;
            check({31'h0, (rd >= 32'(exp - 1)) && (rd <= 32'(exp + 1))}, 1);
            wait fork;
        end
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_up();
        t_down();
        t_alarm_in();
        t_meas();
        stop_test();
    end

    initial begin
        repeat (100000) @(posedge hclk);
        fail_count++;
        stop_test();
    end
endmodule // uic_top_tb
